// File: verilog/sensor_output_datapath_config.sv
/*
  Output datapath configuration bank: serial configuration port, black
  level calibration of the pixel stream, a two-entry buffer and the
  crossing to the link clock where lane words are produced.
  Assumes pixel inputs are on mclk_i, the serial port pins are
  asynchronous and much slower than mclk_i, and lclk_i runs free.
*/
// Summary of operation
// - Clock lane on only while its bit set
// - Sync channel on only while its bit set
// - Data channels on only while bit set
// - Eight-bit black target, resets to 0x08
// - Average two to the field black samples
// - CRC seed all zeros or all ones
// - Auto calibration enable bit, resets to one
// - Manual offset replaces correction when bypassed
// - Offset direction bit: add or subtract
// - Resolution bit selects width, shifts marks four
// - Idle data channels send training word
// - Four column bias codes held and driven
// - Sync word: three mark bits, seven programmable
// - Fault flag when black samples fall short
`timescale 1ns/1ps
`default_nettype none
`include "sensor_cfg_regs.svh"
module sensor_output_datapath_config #(
  parameter logic [9:0] CRC_POLY = 10'h20f
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic lclk_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic pix_valid_i,
  input wire logic [9:0] pix_data_i,
  input wire logic pix_black_i,
  input wire logic pix_frame_i,
  input wire logic pix_start_i,
  input wire logic pix_stop_i,
  output logic pix_ready_o,
  output logic clk_lane_en_o,
  output logic sync_lane_en_o,
  output logic data_lane_en_o,
  output logic [3:0] column_select_bias_first_o,
  output logic [3:0] column_select_bias_second_o,
  output logic [3:0] column_select_bias_delay_o,
  output logic [3:0] column_select_bias_common_o,
  output logic [7:0] drive_bias_o,
  output logic [9:0] data_word_o,
  output logic [9:0] sync_word_o,
  output logic [9:0] crc_word_o
);
  // Serial port synchronisers and framing
  logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, mosi_s1, mosi_s2;
  logic sclk_rise, sclk_fall, frame_on, wr_stb;
  logic [4:0] bit_cnt;
  logic [23:0] shift_in;
  logic [15:0] rd_shift, rd_data, wr_data;
  logic [7:0] wr_addr, rd_addr;
  // Register storage
  logic [15:0] col_bias, drv_bias, black_cfg, settings;
  logic [15:0] spare [0:3];
  logic [2:0] power;
  logic [9:0] idle_word;
  logic [6:0] marker;
  // Calibration state
  logic [16:0] acc_sum, base_sum, sum_plus;
  logic [7:0] acc_cnt, base_cnt, need;
  logic signed [11:0] corr, manual_delta, cal_delta;
  logic cal_done, cal_fault, accept, auto_on;
  logic [9:0] corrected;
  // Buffer and crossing
  sensor_cfg_pkg::xfer_t fifo [0:1];
  logic wr_ptr, rd_ptr, pop, busy, ack_s1, ack_s2;
  logic [1:0] count, next_count;
  pixel_xfer_if xfer ();

  // Clamped signed shift of a pixel value into the 10-bit range
  function automatic logic [9:0] shift_level(logic [9:0] p, logic signed [11:0] d);
    logic signed [12:0] s;
    s = $signed({3'b000, p}) + $signed({d[11], d});
    if (s < 13'sh0000) begin
      return 10'h000;
    end else if (s > 13'sh03ff) begin
      return 10'h3ff;
    end else begin
      return s[9:0];
    end
  endfunction

  // Mean of a power-of-two sample block
  function automatic logic [9:0] black_mean(logic [16:0] s, logic [2:0] n);
    logic [16:0] t;
    t = s >> n;
    return t[9:0];
  endfunction

  // Pins are asynchronous; two flops before use, third only for edges
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= spi_sclk_i;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= spi_cs_n_i;
      cs_s2 <= cs_s1;
      mosi_s1 <= spi_mosi_i;
      mosi_s2 <= mosi_s1;
    end
  end
  assign frame_on = ~cs_s2;
  assign sclk_rise = frame_on & sclk_s2 & ~sclk_s3;
  assign sclk_fall = frame_on & ~sclk_s2 & sclk_s3;

  // Frame: write flag, 8 address bits, 16 data bits, MSB first
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_cnt <= 5'h00;
      shift_in <= 24'h000000;
    end else if (!frame_on) begin
      bit_cnt <= 5'h00;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[22:0], mosi_s2};
      if (bit_cnt != 5'h19) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end
  assign wr_stb = sclk_rise & (bit_cnt == `SPI_LAST_BIT) & shift_in[23];
  assign wr_addr = shift_in[22:15];
  assign wr_data = {shift_in[14:0], mosi_s2};
  assign rd_addr = {shift_in[6:0], mosi_s2};

  // Read data loads once the address is in, shifts out on falling edges
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_shift <= 16'h0000;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= frame_on;
      if (sclk_rise && bit_cnt == `SPI_ADDR_DONE) begin
        rd_shift <= rd_data;
      end else if (sclk_fall && bit_cnt > `SPI_ADDR_DONE && bit_cnt < 5'h19) begin
        spi_miso_o <= rd_shift[15];
        rd_shift <= {rd_shift[14:0], 1'b0};
      end
    end
  end

  // Read decode; unmapped offsets and the read-only spare read zero
  always_comb begin
    case (rd_addr)
      `OFF_COL_BIAS: rd_data = col_bias;
      `OFF_DRV_BIAS: rd_data = drv_bias;
      `OFF_SPARE_70: rd_data = spare[0];
      `OFF_SPARE_80: rd_data = spare[1];
      `OFF_SPARE_81: rd_data = spare[2];
      `OFF_SPARE_96: rd_data = spare[3];
      `OFF_POWER: rd_data = {13'h0000, power};
      `OFF_BLACK: rd_data = black_cfg;
      `OFF_SETTINGS: rd_data = settings;
      `OFF_IDLE_WORD: rd_data = {6'h00, idle_word};
      `OFF_MARKER: rd_data = {9'h000, marker};
      `OFF_CAL_FAULT: rd_data = {15'h0000, cal_fault};
      default: rd_data = 16'h0000;
    endcase
  end

  // Register writes at the last bit of a write frame
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      col_bias <= `RST_COL_BIAS;
      drv_bias <= `RST_DRV_BIAS;
      spare[0] <= `RST_SPARE_70;
      spare[1] <= `RST_SPARE_TEST;
      spare[2] <= `RST_SPARE_TEST;
      spare[3] <= `RST_SPARE_TEST;
      power <= `RST_POWER;
      black_cfg <= `RST_BLACK;
      settings <= `RST_SETTINGS;
      idle_word <= `RST_IDLE_WORD;
      marker <= `RST_MARKER;
    end else if (wr_stb) begin
      case (wr_addr)
        `OFF_COL_BIAS: col_bias <= wr_data;
        `OFF_DRV_BIAS: drv_bias <= wr_data;
        `OFF_SPARE_70: spare[0] <= wr_data;
        `OFF_SPARE_80: spare[1] <= wr_data;
        `OFF_SPARE_81: spare[2] <= wr_data;
        `OFF_SPARE_96: spare[3] <= wr_data;
        `OFF_POWER: power <= wr_data[2:0];
        `OFF_BLACK: black_cfg <= wr_data;
        `OFF_SETTINGS: settings <= wr_data;
        `OFF_IDLE_WORD: idle_word <= wr_data[9:0];
        `OFF_MARKER: marker <= wr_data[6:0];
        default: ;
      endcase
    end
  end

  // Lane power and bias codes straight from register flops
  assign clk_lane_en_o = power[`POS_PWR_CLK];
  assign sync_lane_en_o = power[`POS_PWR_SYNC];
  assign data_lane_en_o = power[`POS_PWR_DATA];
  assign column_select_bias_first_o = col_bias[3:0];
  assign column_select_bias_second_o = col_bias[7:4];
  assign column_select_bias_delay_o = col_bias[11:8];
  assign column_select_bias_common_o = col_bias[15:12];
  assign drive_bias_o = drv_bias[7:0];

  // Sample target and block accumulation, restarted at each window start
  assign accept = pix_valid_i & pix_ready_o;
  assign auto_on = settings[`POS_AUTO];
  assign need = 8'h01 << black_cfg[`POS_SAMPLES_HI:`POS_SAMPLES_LO];
  assign base_sum = pix_start_i ? 17'h00000 : acc_sum;
  assign base_cnt = pix_start_i ? 8'h00 : acc_cnt;
  assign sum_plus = base_sum + {7'h00, pix_data_i};

  // Black averaging; a short black run flags the calibration invalid
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_sum <= 17'h00000;
      acc_cnt <= 8'h00;
      corr <= 12'sh000;
      cal_done <= 1'b0;
      cal_fault <= 1'b0;
    end else if (accept && auto_on) begin
      acc_sum <= base_sum;
      acc_cnt <= base_cnt;
      if (pix_black_i && base_cnt < need) begin
        acc_sum <= sum_plus;
        acc_cnt <= base_cnt + 8'h01;
        if (base_cnt + 8'h01 == need) begin
          // Move block mean onto the target
          corr <= $signed({4'h0, black_cfg[`POS_TARGET_HI:`POS_TARGET_LO]})
            - $signed({2'b00, black_mean(sum_plus, black_cfg[10:8])});
          cal_done <= 1'b1;
          cal_fault <= 1'b0;
        end
      end else if (!pix_black_i && base_cnt < need) begin
        cal_fault <= 1'b1;
      end
    end
  end

  // Manual offset signed by direction bit; used only when auto is off
  assign manual_delta = settings[`POS_OFFSET_DEC] ?
    -$signed({3'b000, settings[`POS_OFFSET_HI:`POS_OFFSET_LO]}) :
    $signed({3'b000, settings[`POS_OFFSET_HI:`POS_OFFSET_LO]});
  // In auto mode, before the first block completes the stream passes unchanged
  assign cal_delta = auto_on ? (cal_done ? corr : 12'sh000) : manual_delta;
  assign corrected = shift_level(pix_data_i, cal_delta);

  // Two-entry buffer occupancy; ready is registered from next occupancy
  assign pop = ~busy & (count != 2'h0);
  always_comb begin
    next_count = count;
    if (accept && !pop) begin
      next_count = count + 2'h1;
    end else if (!accept && pop) begin
      next_count = count - 2'h1;
    end
  end

  // Buffer storage and pointers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      pix_ready_o <= 1'b0;
      fifo[0] <= '0;
      fifo[1] <= '0;
    end else begin
      count <= next_count;
      pix_ready_o <= (next_count != 2'h2);
      if (accept) begin
        fifo[wr_ptr] <= '{pix: corrected, frame: pix_frame_i,
                          start: pix_start_i, stop: pix_stop_i};
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
    end
  end

  // Sender: one word in flight; held until the toggle comes back
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      xfer.req <= 1'b0;
      xfer.word <= '0;
    end else begin
      ack_s1 <= xfer.ack;
      ack_s2 <= ack_s1;
      if (pop) begin
        xfer.word <= fifo[rd_ptr];
        xfer.req <= ~xfer.req;
      end
    end
  end
  assign busy = xfer.req ^ ack_s2;

  // Link-side lane words and CRC
  serial_lane_tx #(
    .CRC_POLY(CRC_POLY)
  ) u_lane_tx (
    .lclk_i(lclk_i),
    .sys_rst_i(sys_rst_i),
    .lnk(xfer.dst),
    .cfg_i({power[`POS_PWR_DATA], power[`POS_PWR_SYNC], black_cfg[`POS_SEED],
            settings[`POS_NARROW], idle_word, marker}),
    .data_word_o(data_word_o),
    .sync_word_o(sync_word_o),
    .crc_word_o(crc_word_o)
  );
endmodule
`default_nettype wire

// File: include/sensor_cfg_regs.svh
/*
  Offsets, field positions, reset values and timing counts of the output
  datapath configuration bank.
  Assumes it is included by bare name, once per compilation unit or more.
*/
`ifndef SENSOR_CFG_REGS_SVH
`define SENSOR_CFG_REGS_SVH
// Register offsets on the serial configuration port
`define OFF_COL_BIAS 8'h43
`define OFF_DRV_BIAS 8'h44
`define OFF_SPARE_70 8'h46
`define OFF_SPARE_80 8'h50
`define OFF_SPARE_81 8'h51
`define OFF_SPARE_96 8'h60
`define OFF_SPARE_97 8'h61
`define OFF_POWER 8'h70
`define OFF_BLACK 8'h80
`define OFF_SETTINGS 8'h81
`define OFF_IDLE_WORD 8'h82
`define OFF_MARKER 8'h83
`define OFF_CAL_FAULT 8'h88
// Reset values
`define RST_COL_BIAS 16'h8888
`define RST_DRV_BIAS 16'h0088
`define RST_SPARE_70 16'h8888
`define RST_SPARE_TEST 16'h0000
`define RST_POWER 3'h0
`define RST_BLACK 16'h4008
`define RST_SETTINGS 16'hc001
`define RST_IDLE_WORD 10'h3a6
`define RST_MARKER 7'h2a
// Field positions
`define POS_PWR_CLK 0
`define POS_PWR_SYNC 1
`define POS_PWR_DATA 2
`define POS_TARGET_HI 7
`define POS_TARGET_LO 0
`define POS_SAMPLES_HI 10
`define POS_SAMPLES_LO 8
`define POS_SEED 15
`define POS_AUTO 0
`define POS_OFFSET_HI 9
`define POS_OFFSET_LO 1
`define POS_OFFSET_DEC 10
`define POS_NARROW 13
// Timing counts
`define NARROW_SHIFT 4
`define SPI_ADDR_DONE 5'h08
`define SPI_LAST_BIT 5'h18
`endif

// File: include/sensor_cfg_pkg.sv
/*
  Types shared by the configuration bank and its link-side transmitter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sensor_cfg_pkg;
  typedef logic [9:0] word10_t;
  // One pixel word with its window marks
  typedef struct packed {
    word10_t pix;
    logic frame;
    logic start;
    logic stop;
  } xfer_t;
endpackage

// File: include/pixel_xfer_if.sv
/*
  Toggle handshake carrying pixel words from the system clock domain to
  the link clock domain.
  Assumes the source holds word steady while req differs from ack.
*/
`timescale 1ns/1ps
`default_nettype none
interface pixel_xfer_if;
  logic req;
  logic ack;
  sensor_cfg_pkg::xfer_t word;
  modport src (output req, output word, input ack);
  modport dst (input req, input word, output ack);
endinterface
`default_nettype wire

// File: verilog/serial_lane_tx.sv
/*
  Link-side word generator for the data and sync channels and the CRC.
  Assumes lclk_i runs free, config inputs change rarely, and the source
  side of the handshake keeps its word stable until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sensor_cfg_regs.svh"
module serial_lane_tx #(
  parameter logic [9:0] CRC_POLY = 10'h20f
) (
  input wire logic lclk_i,
  input wire logic sys_rst_i,
  pixel_xfer_if.dst lnk,
  input wire logic [20:0] cfg_i,
  output logic [9:0] data_word_o,
  output logic [9:0] sync_word_o,
  output logic [9:0] crc_word_o
);
  logic rst_l1, rst_l2;
  logic [20:0] cfg_s1, cfg_s2, cfg_s3, cfg_q;
  logic req_s1, req_s2, req_s3;
  logic [9:0] dly [0:`NARROW_SHIFT-1];
  logic [9:0] crc, next_word, next_sync;
  logic take, seed_one, narrow, pwr_sync, pwr_data;
  logic [9:0] idle_word;
  logic [6:0] marker;

  // One CRC step over a whole word, bit serial MSB first
  function automatic logic [9:0] crc_step(logic [9:0] c, logic [9:0] d);
    logic [9:0] r;
    r = c;
    for (int i = 9; i >= 0; i--) begin
      r = (r[9] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Reset release retimed to the link clock
  always_ff @(posedge lclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_l1 <= 1'b1;
      rst_l2 <= 1'b1;
    end else begin
      rst_l1 <= 1'b0;
      rst_l2 <= rst_l1;
    end
  end

  // Config is quasi static; take it only when two samples agree
  always_ff @(posedge lclk_i or posedge rst_l2) begin
    if (rst_l2) begin
      cfg_s1 <= 21'h000000;
      cfg_s2 <= 21'h000000;
      cfg_s3 <= 21'h000000;
      cfg_q <= {2'b00, 1'b0, 1'b0, `RST_IDLE_WORD, `RST_MARKER};
    end else begin
      cfg_s1 <= cfg_i;
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
      if (cfg_s2 == cfg_s3) begin
        cfg_q <= cfg_s2;
      end
    end
  end
  assign {pwr_data, pwr_sync, seed_one, narrow, idle_word, marker} = cfg_q;

  // Request toggle crossing; ack echoes the synchronised request
  always_ff @(posedge lclk_i or posedge rst_l2) begin
    if (rst_l2) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      lnk.ack <= 1'b0;
    end else begin
      req_s1 <= lnk.req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      lnk.ack <= req_s2;
    end
  end
  assign take = req_s2 ^ req_s3;

  // Pixel word or idle training word; sync gets a marker or training
  always_comb begin
    next_word = idle_word;
    next_sync = idle_word;
    if (take) begin
      next_word = narrow ? {2'b00, lnk.word.pix[9:2]} : lnk.word.pix;
      if (lnk.word.start || lnk.word.stop) begin
        next_sync = {lnk.word.frame, lnk.word.start, lnk.word.stop, marker};
      end
    end
  end

  // Lane words, zero while the channel is powered down
  always_ff @(posedge lclk_i or posedge rst_l2) begin
    if (rst_l2) begin
      data_word_o <= 10'h000;
      sync_word_o <= 10'h000;
      for (int i = 0; i < `NARROW_SHIFT; i++) begin
        dly[i] <= 10'h000;
      end
    end else begin
      dly[0] <= next_sync;
      for (int i = 1; i < `NARROW_SHIFT; i++) begin
        dly[i] <= dly[i-1];
      end
      data_word_o <= pwr_data ? next_word : 10'h000;
      // Window marks lag by the shift count in narrow mode
      sync_word_o <= pwr_sync ? (narrow ? dly[`NARROW_SHIFT-1] : next_sync) : 10'h000;
    end
  end

  // CRC restarts from the selected seed at each window start
  always_ff @(posedge lclk_i or posedge rst_l2) begin
    if (rst_l2) begin
      crc <= 10'h000;
      crc_word_o <= 10'h000;
    end else begin
      if (take) begin
        crc <= crc_step(lnk.word.start ? {10{seed_one}} : crc, next_word);
      end
      crc_word_o <= crc;
    end
  end
endmodule
`default_nettype wire

// File: bench/sensor_output_datapath_config_props.sv
/*
  Port checker for the output datapath configuration bank.
  Assumes it is bound onto the top module and sclk phases of 5 mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_output_datapath_config_props (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic lclk_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic pix_valid_i,
  input wire logic pix_ready_o,
  input wire logic clk_lane_en_o,
  input wire logic sync_lane_en_o,
  input wire logic data_lane_en_o,
  input wire logic [3:0] column_select_bias_first_o,
  input wire logic [3:0] column_select_bias_second_o,
  input wire logic [3:0] column_select_bias_delay_o,
  input wire logic [3:0] column_select_bias_common_o,
  input wire logic [7:0] drive_bias_o,
  input wire logic [9:0] data_word_o,
  input wire logic [9:0] sync_word_o
);
  // Read driver follows the synced select
  a_oe_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !spi_cs_n_i [*4] |-> spi_miso_oe_o) else $error("miso enable missing");
  a_oe_drop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    spi_cs_n_i [*4] |-> !spi_miso_oe_o) else $error("miso enable stuck");
  // Settings only move inside a frame
  a_power_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    spi_cs_n_i [*8] |-> $stable({clk_lane_en_o, sync_lane_en_o, data_lane_en_o}))
    else $error("power bits moved outside a frame");
  a_bias_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    spi_cs_n_i [*8] |-> $stable({column_select_bias_first_o, column_select_bias_second_o,
    column_select_bias_delay_o, column_select_bias_common_o, drive_bias_o}))
    else $error("bias codes moved outside a frame");
  // Buffer only fills on an accepted word
  a_ready_fall: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $fell(pix_ready_o) |-> $past(pix_valid_i)) else $error("ready fell with no word");
  // Host samples on rises, so miso moves in the low phase only
  a_miso_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $changed(spi_miso_o) |-> !spi_sclk_i) else $error("miso moved while sclk high");
  // Unpowered lanes carry nothing
  a_data_off: assert property (@(posedge lclk_i) disable iff (sys_rst_i)
    !data_lane_en_o [*8] |-> data_word_o == 10'h000) else $error("data lane active");
  a_sync_off: assert property (@(posedge lclk_i) disable iff (sys_rst_i)
    !sync_lane_en_o [*8] |-> sync_word_o == 10'h000) else $error("sync lane active");
endmodule
`default_nettype wire

// File: bench/lane_receiver_model.sv
/*
  Receiver at the far end of the lanes: word alignment and capture.
  Assumes lane words arrive one per link clock, already deserialized.
*/
`timescale 1ns/1ps
`default_nettype none
module lane_receiver_model (
  input wire logic lclk_i,
  input wire logic sys_rst_i,
  input wire logic [9:0] data_word_i,
  input wire logic [9:0] sync_word_i,
  input wire logic [9:0] train_i,
  output logic aligned_o
);
  logic [9:0] words[$];
  logic [9:0] marks[$];
  logic [2:0] run;
  // Lock after a run of training words; payload is anything else
  always @(posedge lclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run <= 3'h0;
      aligned_o <= 1'b0;
    end else if (data_word_i === train_i) begin
      if (run != 3'h4) run <= run + 3'h1;
      else aligned_o <= 1'b1;
    end else begin
      run <= 3'h0;
      if (aligned_o) words.push_back(data_word_i);
    end
    // Marker words only count once locked
    if (!sys_rst_i && aligned_o && sync_word_i !== train_i) marks.push_back(sync_word_i);
  end
endmodule
`default_nettype wire

// File: bench/sensor_output_datapath_config_test.sv
/*
  Self-checking bench: register bank over the serial port, calibration,
  buffer refusal and lane words seen by the receiver model.
  Assumes the design and lane_receiver_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_output_datapath_config_test;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic mosi = 1'b0;
  logic pv = 1'b0;
  logic [9:0] pd = 10'h000;
  logic pb = 1'b0;
  logic pf = 1'b0;
  logic ps = 1'b0;
  logic pe = 1'b0;
  logic miso, oe, pr, c_en, s_en, d_en, aligned;
  logic [3:0] b1, b2, b3, b4;
  logic [7:0] drv;
  logic [9:0] dw, sw, cw, p, v, t;
  logic [15:0] q;
  logic [31:0] seed = 32'hd44f;
  int err_count = 0;
  int n_compared = 0;
  int refused = 0;
  logic [7:0] radr[13] = '{8'h43, 8'h44, 8'h46, 8'h50, 8'h51, 8'h60, 8'h61, 8'h70,
    8'h80, 8'h81, 8'h82, 8'h83, 8'hf0};
  logic [15:0] rrst[13] = '{16'h8888, 16'h0088, 16'h8888, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h4008, 16'hc001, 16'h03a6, 16'h002a, 16'h0000};
  // Link clock edges land on mclk falling edges, never on its rising edges
  always #2 mclk = ~mclk;
  always #16 lclk = ~lclk;
  sensor_output_datapath_config DUT (.mclk_i(mclk), .sys_rst_i(sys_rst), .lclk_i(lclk),
    .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(oe), .pix_valid_i(pv), .pix_data_i(pd), .pix_black_i(pb),
    .pix_frame_i(pf), .pix_start_i(ps), .pix_stop_i(pe), .pix_ready_o(pr),
    .clk_lane_en_o(c_en), .sync_lane_en_o(s_en), .data_lane_en_o(d_en),
    .column_select_bias_first_o(b1), .column_select_bias_second_o(b2),
    .column_select_bias_delay_o(b3), .column_select_bias_common_o(b4),
    .drive_bias_o(drv), .data_word_o(dw), .sync_word_o(sw), .crc_word_o(cw));
  lane_receiver_model rx (.lclk_i(lclk), .sys_rst_i(sys_rst), .data_word_i(dw),
    .sync_word_i(sw), .train_i(10'h3a6), .aligned_o(aligned));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  // Lane CRC, one bit at a time, MSB first
  function automatic logic [9:0] crc_of(input logic [9:0] c, input logic [9:0] d);
    for (int i = 9; i >= 0; i--) c = (c[9] ^ d[i]) ? ((c << 1) ^ 10'h20f) : (c << 1);
    return c;
  endfunction
  // Output saturates rather than wrapping
  function automatic logic [9:0] clamp(input int x);
    return (x < 0) ? 10'h000 : (x > 1023) ? 10'h3ff : x[9:0];
  endfunction
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic half;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  // Mode 0 frame: flag, address, data, MSB first
  task automatic spi(input logic w, input logic [7:0] a, input logic [15:0] d);
    logic [24:0] f;
    f = {w, a, d};
    cs_n = 1'b0;
    for (int i = 24; i >= 0; i--) begin
      mosi = f[i];
      half();
      sclk = 1'b1;
      if (i < 16) q[i] = miso;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    repeat (8) half(); // Link config settles
  endtask
  // Holds valid across words so bursts go back to back
  task automatic put(input logic [9:0] x, input logic [3:0] m);
    {pb, pf, ps, pe} = m;
    pd = x;
    pv = 1'b1;
    for (int k = 0; k < 500 && pr !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
      refused++;
    end
    if (pr !== 1'b1) begin
      check(16'h0000, 16'h0001);
      wrap_up();
    end
    @(posedge mclk);
    #1;
  endtask
  task automatic wait_rx(input int n);
    pv = 1'b0;
    for (int k = 0; k < 3000 && rx.words.size() < n; k++) begin
      @(posedge mclk);
      #1;
    end
    if (rx.words.size() < n) begin
      check(16'h0000, 16'h0001);
      wrap_up();
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    half();
    check({b4, b3, b2, b1}, 16'h8888);
    check({13'h0, d_en, s_en, c_en}, 16'h0000);
    for (int i = 0; i < 13; i++) begin
      spi(1'b0, radr[i], 16'h0000);
      check(q, rrst[i]);
    end
    for (int i = 0; i < 7; i++) begin
      seed = xs(seed);
      spi(1'b1, radr[i], seed[15:0]);
      spi(1'b0, radr[i], 16'h0000);
      check(q, (i == 6) ? 16'h0000 : seed[15:0]);
      if (i == 0) check({b4, b3, b2, b1}, seed[15:0]);
      if (i == 1) check({8'h00, drv}, {8'h00, seed[7:0]});
    end
    spi(1'b1, 8'hf0, 16'h1234);
    spi(1'b0, 8'hf0, 16'h0000);
    check(q, 16'h0000);
    // Every power combination, ending all on before any traffic
    for (int i = 0; i < 8; i++) begin
      spi(1'b1, 8'h70, {13'h0, i[2:0]});
      check({13'h0, d_en, s_en, c_en}, {13'h0, i[2:0]});
    end
    for (int k = 0; k < 400 && aligned !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    check({15'h0, aligned}, 16'h0001);
    check({6'h0, sw}, 16'h03a6);
    // Manual offset, both directions, both widths; first forces clamp at zero
    for (int j = 0; j < 8; j++) begin
      seed = xs(seed);
      p = (j == 0) ? 10'h003 : {1'b0, seed[24:16]};
      spi(1'b1, 8'h81, {2'b11, seed[9], 1'b0, 1'b0, seed[8] | (j == 0), 1'b0, seed[7:0], 1'b0});
      put(p, 4'h0);
      wait_rx(1);
      v = (seed[8] | (j == 0)) ? clamp(p - seed[7:0]) : clamp(p + seed[7:0]);
      check(rx.words.pop_front(), seed[9] ? {8'h00, v[9:2]} : v);
    end
    // Burst against the link rate fills the buffer
    spi(1'b1, 8'h81, 16'hc000);
    refused = 0;
    for (int j = 0; j < 6; j++) put(10'h020 * j + 10'h011, 4'h0);
    wait_rx(6);
    for (int j = 0; j < 6; j++) check(rx.words.pop_front(), 10'h020 * j + 10'h011);
    check({15'h0, refused > 0}, 16'h0001);
    // Auto mode: non-black word before the block completes
    seed = xs(seed);
    t = {2'b00, seed[7:0]};
    v = {3'b000, seed[14:8]};
    spi(1'b1, 8'h80, {5'h18, 3'h2, t[7:0]});
    spi(1'b1, 8'h81, 16'hc001);
    rx.marks.delete();
    put(v, 4'b1110);
    put(10'h100, 4'h0);
    wait_rx(2);
    spi(1'b0, 8'h88, 16'h0000);
    check(q, 16'h0001);
    check(rx.marks.pop_front(), 10'h32a);
    // Four unequal black samples, then a pixel moved by target minus mean
    rx.words.delete();
    put(v, 4'b1110);
    put(v, 4'b1000);
    put(v + 10'h008, 4'b1000);
    put(v + 10'h008, 4'b1000);
    put(10'h155, 4'h0);
    wait_rx(5);
    check(rx.words[4], clamp(10'h155 + t - v - 4));
    p = 10'h3ff;
    for (int j = 0; j < 5; j++) p = crc_of(p, rx.words[j]);
    check(cw, p);
    spi(1'b0, 8'h88, 16'h0000);
    check(q, 16'h0000);
    wrap_up();
  end
endmodule
bind sensor_output_datapath_config sensor_output_datapath_config_props chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .lclk_i(lclk_i), .spi_sclk_i(spi_sclk_i),
  .spi_cs_n_i(spi_cs_n_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
  .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .clk_lane_en_o(clk_lane_en_o),
  .sync_lane_en_o(sync_lane_en_o), .data_lane_en_o(data_lane_en_o),
  .column_select_bias_first_o(column_select_bias_first_o),
  .column_select_bias_second_o(column_select_bias_second_o),
  .column_select_bias_delay_o(column_select_bias_delay_o),
  .column_select_bias_common_o(column_select_bias_common_o),
  .drive_bias_o(drive_bias_o), .data_word_o(data_word_o), .sync_word_o(sync_word_o));
`default_nettype wire
